// >>> logic/card_cmd_pkg.sv
// constants and types shared by the card file access command logic
package card_cmd_pkg;

    // command kinds, decoded from the instruction byte by the link layer
    typedef enum logic [1:0] {
        OP_STATUS,
        OP_TREAD,
        OP_TUPDATE,
        OP_RREAD
    } op_e;

    // object the link layer must send after a status query
    typedef enum logic [1:0] {
        OBJ_NONE,
        OBJ_CTRL_PARAMS,
        OBJ_NAME
    } obj_e;

    // file sizes
    localparam int TF_SIZE = 256;
    localparam int NREC = 8;
    localparam int RLEN = 8;
    localparam logic [8:0] TF_SIZE_W = 9'h100;
    localparam logic [3:0] NREC_W = 4'h8;
    localparam logic [8:0] RLEN_W = 9'h008;
    localparam logic [8:0] LE_MAX = 9'h100;

    // parameter field codes
    localparam logic [7:0] P_STAT_NONE = 8'h00;
    localparam logic [7:0] P_STAT_INIT = 8'h01;
    localparam logic [7:0] P_STAT_TERM = 8'h02;
    localparam logic [7:0] P_OBJ_SEL = 8'h00;
    localparam logic [7:0] P_OBJ_NAME = 8'h01;
    localparam logic [7:0] P_OBJ_NONE = 8'h0C;
    localparam logic [2:0] M_NEXT = 3'h2;
    localparam logic [2:0] M_PREV = 3'h3;
    localparam logic [2:0] M_ABS = 3'h4;
    localparam logic [4:0] SID_RESERVED = 5'h1F;

    // status words
    localparam logic [15:0] SW_OK = 16'h9000;
    localparam logic [15:0] SW_BAD_P = 16'h6A86;
    localparam logic [15:0] SW_NO_FILE = 16'h6A82;
    localparam logic [15:0] SW_NO_REC = 16'h6A83;
    localparam logic [15:0] SW_RANGE = 16'h6B00;
    localparam logic [15:0] SW_ACCESS = 16'h6982;
    localparam logic [15:0] SW_WRONG_LEN = 16'h6700;

    // reset values
    localparam logic [1:0] APP_RST = 2'h0;

endpackage

// >>> logic/card_file_access.sv
// card side executor for status, transparent and record read commands
// Notes on behaviour
// - status first parameter: 0 no indication, 1 initialised, 2 terminating
// - status second parameter: 0 select answer, 1 name object, 0x0C none
// - transparent read returns bytes of current file when read allowed
// - first byte bit8 clear: bits7-1 high offset, second byte low offset
// - bit8 set, bits7-6 clear: bits5-1 short id, second byte offset
// - transparent read returns exactly expected-length bytes, no command data
// - transparent update overwrites bytes from offset when update allowed
// - update decodes parameters as read; data length gives byte count
// - record read returns one whole record when read allowed
// - failed record read leaves record pointer alone
// - current and absolute modes read without moving the pointer
// - next mode increments first; unset pointer reads first record
// - next at last record of linear file: pointer kept, no data
// - next at last record of cyclic file wraps to first
// - previous mode decrements first; unset pointer reads last record
// - previous at first record of linear file: pointer kept, no data
// - previous at first record of cyclic file wraps to last
// - record read bits8-4: zero current file, else short id 1 to 30
// - mode bits: 010 next, 011 previous, 100 absolute, or current when record number is zero; other modes rejected
`timescale 1ns/100ps
`default_nettype none
module card_file_access
    import card_cmd_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // command header
    input wire logic cmd_valid,
    input wire op_e cmd_op,
    input wire logic [7:0] cmd_p1,
    input wire logic [7:0] cmd_p2,
    input wire logic [7:0] cmd_len,
    // selected file and access conditions
    input wire logic sel_change,
    input wire logic sel_transparent,
    input wire logic sel_record,
    input wire logic rec_cyclic,
    input wire logic [4:0] tf_short_id,
    input wire logic [4:0] rf_short_id,
    input wire logic read_ok,
    input wire logic update_ok,
    // record content loading
    input wire logic rec_load_valid,
    input wire logic [5:0] rec_load_addr,
    input wire logic [7:0] rec_load_data,
    // update data in
    input wire logic wr_valid,
    input wire logic [7:0] wr_data,
    output logic wr_ready,
    // response data out
    output logic rd_valid,
    output logic [7:0] rd_data,
    // completion
    output logic busy,
    output logic done,
    output logic [15:0] sw,
    output logic [1:0] app_state,
    output obj_e status_obj,
    output logic [3:0] rec_ptr,
    output logic rec_ptr_set
);

    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_TRD,
        ST_TWR,
        ST_RRD
    } st_e;

    typedef struct packed {
        st_e st;
        logic [8:0] addr;
        logic [8:0] cnt;
        logic [3:0] ptr;
        logic ptr_set;
        logic [1:0] app;
        obj_e obj;
        logic [15:0] sw;
        logic done;
        logic busy;
        logic rd_valid;
        logic [7:0] rd_data;
        logic wr_ready;
    } state_s;

    state_s r_q, r_d;
    logic [7:0] tmem [TF_SIZE];
    logic [7:0] rmem [NREC*RLEN];

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [14:0] off;
        logic [8:0] len;
        logic [4:0] sid;
        logic [3:0] tgt;
        logic pok;
        logic fok;
        logic rok;
        logic [15:0] err;
        off = '0;
        len = '0;
        sid = '0;
        tgt = '0;
        pok = 1'b1;
        fok = 1'b0;
        rok = 1'b1;
        err = SW_OK;
        r_d = r_q;
        r_d.done = 1'b0;
        r_d.rd_valid = 1'b0;
        if (sel_change) begin
            r_d.ptr_set = 1'b0;
        end
        case (r_q.st)
        ST_IDLE: begin
            if (cmd_valid) begin
                if (cmd_op == OP_STATUS) begin
                    if (cmd_p1 > P_STAT_TERM) begin
                        err = SW_BAD_P;
                    end else if (cmd_p2 == P_OBJ_SEL) begin
                        r_d.obj = OBJ_CTRL_PARAMS;
                    end else if (cmd_p2 == P_OBJ_NAME) begin
                        r_d.obj = OBJ_NAME;
                    end else if (cmd_p2 == P_OBJ_NONE) begin
                        r_d.obj = OBJ_NONE;
                    end else begin
                        err = SW_BAD_P;
                    end
                    if (err == SW_OK) begin
                        r_d.app = cmd_p1[1:0];
                    end
                    r_d.sw = err;
                    r_d.done = 1'b1;
                end else if (cmd_op != OP_RREAD) begin
                    // both transparent commands share one decode
                    if (!cmd_p1[7]) begin
                        off = {cmd_p1[6:0], cmd_p2};
                        fok = sel_transparent;
                    end else if (cmd_p1[6:5] == 2'b00) begin
                        off = {7'h00, cmd_p2};
                        fok = (cmd_p1[4:0] == tf_short_id);
                    end else begin
                        pok = 1'b0;
                    end
                    // zero expected length asks for the maximum
                    if (cmd_op == OP_TREAD && cmd_len == 8'h00) begin
                        len = LE_MAX;
                    end else begin
                        len = {1'b0, cmd_len};
                    end
                    if (!pok) begin
                        err = SW_BAD_P;
                    end else if (!fok) begin
                        err = SW_NO_FILE;
                    end else if (cmd_op == OP_TREAD && !read_ok) begin
                        err = SW_ACCESS;
                    end else if (cmd_op == OP_TUPDATE && !update_ok) begin
                        err = SW_ACCESS;
                    end else if (len == 9'h000) begin
                        err = SW_WRONG_LEN;
                    end else if ({1'b0, off} + {7'h00, len} >
                                 {7'h00, TF_SIZE_W}) begin
                        err = SW_RANGE;
                    end
                    if (err != SW_OK) begin
                        r_d.sw = err;
                        r_d.done = 1'b1;
                    end else begin
                        r_d.addr = off[8:0];
                        r_d.cnt = len;
                        r_d.busy = 1'b1;
                        if (cmd_op == OP_TREAD) begin
                            r_d.st = ST_TRD;
                        end else begin
                            r_d.st = ST_TWR;
                            r_d.wr_ready = 1'b1;
                        end
                    end
                end else begin
                    sid = cmd_p2[7:3];
                    if (sid == 5'h00) begin
                        fok = sel_record;
                    end else if (sid == SID_RESERVED) begin
                        pok = 1'b0;
                    end else begin
                        fok = (sid == rf_short_id);
                    end
                    case (cmd_p2[2:0])
                    M_NEXT: begin
                        if (!r_q.ptr_set) begin
                            tgt = 4'h1;
                        end else if (r_q.ptr == NREC_W) begin
                            tgt = 4'h1;
                            rok = rec_cyclic;
                        end else begin
                            tgt = r_q.ptr + 4'h1;
                        end
                    end
                    M_PREV: begin
                        if (!r_q.ptr_set) begin
                            tgt = NREC_W;
                        end else if (r_q.ptr == 4'h1) begin
                            tgt = NREC_W;
                            rok = rec_cyclic;
                        end else begin
                            tgt = r_q.ptr - 4'h1;
                        end
                    end
                    M_ABS: begin
                        if (cmd_p1 == 8'h00) begin
                            tgt = r_q.ptr;
                            rok = r_q.ptr_set;
                        end else begin
                            tgt = cmd_p1[3:0];
                            rok = (cmd_p1 <= {4'h0, NREC_W});
                        end
                    end
                    default: pok = 1'b0;
                    endcase
                    if (!pok) begin
                        err = SW_BAD_P;
                    end else if (!fok) begin
                        err = SW_NO_FILE;
                    end else if (!read_ok) begin
                        err = SW_ACCESS;
                    end else if (cmd_len != 8'h00 &&
                                 {1'b0, cmd_len} != RLEN_W) begin
                        err = SW_WRONG_LEN;
                    end else if (!rok) begin
                        err = SW_NO_REC;
                    end
                    if (err != SW_OK) begin
                        // pointer untouched on every failure
                        r_d.sw = err;
                        r_d.done = 1'b1;
                    end else begin
                        if (cmd_p2[2:0] != M_ABS) begin
                            r_d.ptr = tgt;
                            r_d.ptr_set = 1'b1;
                        end
                        r_d.addr = 9'((tgt - 4'h1) * RLEN);
                        r_d.cnt = RLEN_W;
                        r_d.busy = 1'b1;
                        r_d.st = ST_RRD;
                    end
                end
            end
        end
        ST_TRD, ST_RRD: begin
            // the sink has no stall: one byte leaves every cycle
            r_d.rd_valid = 1'b1;
            if (r_q.st == ST_TRD) begin
                r_d.rd_data = tmem[r_q.addr[7:0]];
            end else begin
                r_d.rd_data = rmem[r_q.addr[5:0]];
            end
            r_d.addr = r_q.addr + 9'h001;
            r_d.cnt = r_q.cnt - 9'h001;
            if (r_q.cnt == 9'h001) begin
                r_d.st = ST_IDLE;
                r_d.busy = 1'b0;
                r_d.done = 1'b1;
                r_d.sw = SW_OK;
            end
        end
        ST_TWR: begin
            if (wr_valid && r_q.wr_ready) begin
                r_d.addr = r_q.addr + 9'h001;
                r_d.cnt = r_q.cnt - 9'h001;
                if (r_q.cnt == 9'h001) begin
                    r_d.wr_ready = 1'b0;
                    r_d.st = ST_IDLE;
                    r_d.busy = 1'b0;
                    r_d.done = 1'b1;
                    r_d.sw = SW_OK;
                end
            end
        end
        default: r_d.st = ST_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (rst) begin
            r_q <= '{st: ST_IDLE, app: APP_RST, obj: OBJ_NONE,
                     sw: SW_OK, default: '0};
        end else begin
            r_q <= r_d;
        end
    end

    // file contents keep no reset; a reset must not erase stored data
    always_ff @(posedge clk) begin
        if (r_q.st == ST_TWR && wr_valid && r_q.wr_ready) begin
            tmem[r_q.addr[7:0]] <= wr_data;
        end
        if (rec_load_valid) begin
            rmem[rec_load_addr] <= rec_load_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign wr_ready = r_q.wr_ready;
    assign rd_valid = r_q.rd_valid;
    assign rd_data = r_q.rd_data;
    assign busy = r_q.busy;
    assign done = r_q.done;
    assign sw = r_q.sw;
    assign app_state = r_q.app;
    assign status_obj = r_q.obj;
    assign rec_ptr = r_q.ptr;
    assign rec_ptr_set = r_q.ptr_set;

endmodule
`default_nettype wire

// >>> verification/card_file_access_checker.sv
// port assertions for the card file access command logic
`timescale 1ns/100ps
`default_nettype none
module card_file_access_checker
    import card_cmd_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // command and file state
    input wire logic cmd_valid,
    input wire op_e cmd_op,
    input wire logic [7:0] cmd_p1,
    input wire logic [7:0] cmd_p2,
    input wire logic [7:0] cmd_len,
    input wire logic sel_change,
    input wire logic sel_record,
    input wire logic rec_cyclic,
    input wire logic read_ok,
    input wire logic update_ok,
    // results
    input wire logic rd_valid,
    input wire logic busy,
    input wire logic done,
    input wire logic [15:0] sw,
    input wire logic [1:0] app_state,
    input wire obj_e status_obj,
    input wire logic [3:0] rec_ptr,
    input wire logic rec_ptr_set
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic acc;
    assign acc = cmd_valid && !busy;
    a_status_app: assert property (acc && cmd_op == OP_STATUS
        && cmd_p1 < 8'h03 && cmd_p2 == P_OBJ_NAME |=> done
        && app_state == $past(cmd_p1[1:0]) && status_obj == OBJ_NAME)
        else $error("status query result wrong");
    a_status_none: assert property (acc && cmd_op == OP_STATUS
        && cmd_p1 < 8'h03 && cmd_p2 == P_OBJ_NONE |=> status_obj == OBJ_NONE)
        else $error("status query object wrong");
    a_read_access: assert property (acc && cmd_op == OP_TREAD
        && !read_ok |=> done && sw != SW_OK && !rd_valid)
        else $error("read ran without access");
    a_upd_access: assert property (acc && cmd_op == OP_TUPDATE
        && !update_ok |=> done && sw != SW_OK && !busy)
        else $error("update ran without access");
    a_read_first: assert property (acc && cmd_op inside {OP_TREAD,
        OP_RREAD} |=> !rd_valid)
        else $error("read data came too early");
    a_fail_keep: assert property (done && sw != SW_OK
        && !$past(sel_change) |-> $stable(rec_ptr) && $stable(rec_ptr_set))
        else $error("failed command moved the pointer");
    a_abs_keep: assert property (acc && cmd_op == OP_RREAD
        && cmd_p2[2:0] == M_ABS |=> $stable(rec_ptr))
        else $error("absolute read moved the pointer");
    a_ptr_cause: assert property ($changed(rec_ptr)
        && !$past(rst) |-> $past(acc && cmd_op == OP_RREAD))
        else $error("pointer moved without a record read");
    a_lin_end: assert property (acc && cmd_op == OP_RREAD
        && cmd_p2[2:0] == M_NEXT && rec_ptr_set && rec_ptr == NREC_W
        && !rec_cyclic |=> done && sw != SW_OK && rec_ptr == NREC_W)
        else $error("next passed the last linear record");
    a_cyc_wrap: assert property (acc && cmd_op == OP_RREAD
        && cmd_p2 == 8'h03 && cmd_p1 == 8'h00 && rec_ptr_set
        && rec_ptr == 4'h1 && rec_cyclic && read_ok && sel_record
        && cmd_len == 8'h00 && !sel_change |=> rec_ptr == NREC_W ##1 rd_valid)
        else $error("previous did not wrap to last record");
endmodule
bind card_file_access card_file_access_checker card_file_access_checker_i (
    .clk, .rst, .cmd_valid, .cmd_op, .cmd_p1, .cmd_p2, .cmd_len,
    .sel_change, .sel_record, .rec_cyclic, .read_ok, .update_ok, .rd_valid,
    .busy, .done, .sw, .app_state, .status_obj, .rec_ptr, .rec_ptr_set
);
`default_nettype wire

// >>> verification/tb_top.sv
// self-checking bench for the card file access command logic
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import card_cmd_pkg::*;
;
    localparam logic [7:0] NX = {5'h00, M_NEXT};
    localparam logic [7:0] PV = {5'h00, M_PREV};
    localparam logic [7:0] AB = {5'h00, M_ABS};
    logic clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, sel_change = 1'b0;
    logic sel_transparent = 1'b1, sel_record = 1'b0, rec_cyclic = 1'b0;
    logic read_ok = 1'b1, update_ok = 1'b1, rec_load_valid = 1'b0;
    logic stall = 1'b0, wr_valid, wr_ready, rd_valid, busy, done;
    op_e cmd_op = OP_STATUS;
    logic [7:0] cmd_p1 = 8'h00, cmd_p2 = 8'h00, cmd_len = 8'h00;
    logic [5:0] rec_load_addr = 6'h00;
    logic [7:0] rec_load_data = 8'h00, wr_data, rd_data;
    logic [15:0] sw;
    logic [1:0] app_state;
    obj_e status_obj;
    logic [3:0] rec_ptr;
    logic rec_ptr_set;
    int mismatches = 0, check_count = 0, cycles = 0;
    logic [7:0] rx [$];
    card_file_access card_file_access_i (
        .clk, .rst, .cmd_valid, .cmd_op, .cmd_p1, .cmd_p2, .cmd_len,
        .sel_change, .sel_transparent, .sel_record, .rec_cyclic,
        .tf_short_id(5'h05), .rf_short_id(5'h0B), .read_ok, .update_ok,
        .rec_load_valid, .rec_load_addr, .rec_load_data, .wr_valid,
        .wr_data, .wr_ready, .rd_valid, .rd_data, .busy, .done, .sw,
        .app_state, .status_obj, .rec_ptr, .rec_ptr_set
    );
    update_source #(.BASE(8'h5A)) update_source_i (
        .clk, .rst, .wr_ready, .stall, .wr_valid, .wr_data
    );
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // one command, gathering every response byte until done
    task automatic run(input op_e op, input logic [7:0] p1, p2, len);
        rx.delete();
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_p1 <= p1;
        cmd_p2 <= p2;
        cmd_len <= len;
        @(posedge clk);
        cmd_valid <= 1'b0;
        repeat (400) begin
            #1;
            if (rd_valid === 1'b1) rx.push_back(rd_data);
            if (done === 1'b1) break;
            @(posedge clk);
        end
    endtask
    task automatic rd_rec(input logic [7:0] p1, p2, input int r, ptr);
        run(OP_RREAD, p1, p2, 8'h00);
        chk("rec ptr", 16'(rec_ptr), 16'(ptr));
        if (r == 0) begin
            chk("rec none", 16'(rx.size()), 16'h0000);
            chk("rec ok", 16'(sw == SW_OK), 16'h0000);
        end else begin
            chk("rec size", 16'(rx.size()), 16'h0008);
            chk("rec first", 16'(rx[0]), 16'(r * 8 - 8));
            chk("rec last", 16'(rx[7]), 16'(r * 8 - 1));
        end
    endtask
    task automatic reselect();
        @(posedge clk);
        sel_change <= 1'b1;
        @(posedge clk);
        sel_change <= 1'b0;
        #1;
        chk("ptr unset", 16'(rec_ptr_set), 16'h0000);
    endtask
    task automatic t_reset();
        @(posedge clk);
        #1;
        chk("reset sw", sw, SW_OK);
        chk("reset app", 16'(app_state), 16'(APP_RST));
    endtask
    task automatic t_status();
        logic [7:0] p2s [3] = '{P_OBJ_SEL, P_OBJ_NAME, P_OBJ_NONE};
        obj_e objs [3] = '{OBJ_CTRL_PARAMS, OBJ_NAME, OBJ_NONE};
        for (int i = 0; i < 3; i++) begin
            run(OP_STATUS, 8'(i), p2s[i], 8'h00);
            chk("status app", 16'(app_state), 16'(i));
            chk("status obj", 16'(status_obj), 16'(objs[i]));
        end
        run(OP_STATUS, 8'h03, P_OBJ_SEL, 8'h00);
        chk("status p1", sw, SW_BAD_P);
        chk("app kept", 16'(app_state), 16'h0002);
        run(OP_STATUS, 8'h00, 8'h02, 8'h00);
        chk("status p2", sw, SW_BAD_P);
    endtask
    task automatic t_binary();
        stall <= 1'b1;
        run(OP_TUPDATE, 8'h00, 8'hFC, 8'h04);
        chk("update sw", sw, SW_OK);
        chk("upd idle", 16'({wr_ready, busy}), 16'h0000);
        run(OP_TREAD, 8'h85, 8'hFC, 8'h04);
        for (int i = 0; i < 4; i++) begin
            chk("read byte", 16'(rx[i]), 16'(8'h5A + i));
        end
        run(OP_TREAD, 8'h00, 8'hFE, 8'h02);
        chk("read off", 16'({rx.size(), rx[1]}), 16'h025D);
        run(OP_TREAD, 8'h01, 8'h00, 8'h01);
        chk("high off", sw, SW_RANGE);
        run(OP_TREAD, 8'hA0, 8'h00, 8'h01);
        chk("p1 rsvd", sw, SW_BAD_P);
        run(OP_TREAD, 8'h86, 8'h00, 8'h01);
        chk("id miss", sw, SW_NO_FILE);
        run(OP_TUPDATE, 8'h00, 8'h00, 8'h00);
        chk("upd len", sw, SW_WRONG_LEN);
        run(OP_TREAD, 8'h00, 8'h00, 8'h00);
        chk("read all", 16'(rx.size()), 16'h0100);
        read_ok <= 1'b0;
        run(OP_TREAD, 8'h00, 8'h00, 8'h01);
        chk("read deny", sw, SW_ACCESS);
        read_ok <= 1'b1;
        update_ok <= 1'b0;
        run(OP_TUPDATE, 8'h00, 8'h00, 8'h01);
        chk("upd deny", sw, SW_ACCESS);
        update_ok <= 1'b1;
    endtask
    task automatic t_records();
        for (int i = 0; i < 64; i++) begin
            @(posedge clk);
            rec_load_valid <= 1'b1;
            rec_load_addr <= 6'(i);
            rec_load_data <= 8'(i);
        end
        @(posedge clk);
        rec_load_valid <= 1'b0;
        sel_transparent <= 1'b0;
        sel_record <= 1'b1;
        reselect();
        rd_rec(8'h00, AB, 0, 0);
        rd_rec(8'h00, NX, 1, 1);
        rd_rec(8'h00, PV, 0, 1);
        rd_rec(8'h05, AB, 5, 1);
        rd_rec(8'h00, AB, 1, 1);
        reselect();
        rd_rec(8'h00, PV, 8, 8);
        rd_rec(8'h00, NX, 0, 8);
        rd_rec(8'h02, {5'h0B, M_ABS}, 2, 8);
        rd_rec(8'h02, {5'h1F, M_ABS}, 0, 8);
        rd_rec(8'h02, {5'h0C, M_ABS}, 0, 8);
        rd_rec(8'h09, AB, 0, 8);
        rd_rec(8'h02, 8'h00, 0, 8);
        read_ok <= 1'b0;
        rd_rec(8'h00, PV, 0, 8);
        read_ok <= 1'b1;
        rec_cyclic <= 1'b1;
        rd_rec(8'h00, NX, 1, 1);
        rd_rec(8'h00, PV, 8, 8);
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        forever #25 clk = ~clk;
    end
    // a hang is cut short well past the expected run length
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            mismatches++;
            test_done();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_status();
        t_binary();
        t_records();
        test_done();
    end
endmodule
`default_nettype wire

// >>> verification/update_source.sv
// terminal side model feeding update bytes to the card
`timescale 1ns/100ps
`default_nettype none
module update_source
    import card_cmd_pkg::*;
#(
    parameter logic [7:0] BASE = 8'h5A
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // byte handshake
    input wire logic wr_ready,
    input wire logic stall,
    output logic wr_valid,
    output logic [7:0] wr_data
);
    logic [7:0] cnt_q;
    logic tog_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= 8'h00;
            tog_q <= 1'b0;
        end else begin
            tog_q <= ~tog_q;
            if (wr_valid && wr_ready) begin
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end
    // gaps on alternate cycles show the card waits for each byte
    assign wr_valid = wr_ready && !(stall && tog_q);
    // idle data is inverted so a stray capture cannot look right
    assign wr_data = wr_valid ? BASE + cnt_q : ~(BASE + cnt_q);
endmodule
`default_nettype wire
